// ### src/cap_header_pkg.sv
package cap_header_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] capability_header_offset   = 12'h040;
	localparam logic [11:0] device_capabilities_offset = 12'h044;
	localparam logic [11:0] lock_control_offset        = 12'h080;

	// ****************************************
	// Fixed field values
	// ****************************************
	localparam logic [7:0] capability_identifier      = 8'h10;
	localparam logic [7:0] following_capability_link  = 8'h64;
	localparam logic [3:0] structure_version          = 4'h1;
	localparam logic [4:0] interrupt_message_number   = 5'h00;
	localparam logic [1:0] phantom_function_bits      = 2'h0;
	localparam logic       wide_tag_supported         = 1'b1;
	localparam logic [2:0] l0s_exit_latency_limit     = 3'h7;
	localparam logic [2:0] l1_exit_latency_limit      = 3'h7;

	// ****************************************
	// Reset values of loadable fields
	// ****************************************
	localparam logic [3:0] port_type_reset            = 4'h0;
	localparam logic       slot_present_reset         = 1'b0;
	localparam logic [2:0] largest_payload_reset      = 3'h4;
	localparam logic [2:0] indicator_presence_reset   = 3'h0;
	localparam logic       lock_open_reset            = 1'b0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int port_type_lsb       = 20;
	localparam int slot_present_bit    = 24;
	localparam int payload_lsb         = 0;
	localparam int button_present_bit  = 12;

	// AXI4-Lite responses
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// ### src/pcie_capability_header_regs.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pcie_capability_header_regs
	import cap_header_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        eeprom_load,
	input  wire logic [3:0]  eeprom_port_type,
	input  wire logic        eeprom_slot_present,
	input  wire logic [2:0]  eeprom_largest_payload,
	input  wire logic [2:0]  eeprom_indicator_presence,
	output var  logic        lock_open
);
	import cap_header_pkg::*;

	// Bus timing seen from a master:
	// - each ready pulses for one cycle, then rests for one cycle,
	//   and stays low while its write half is held or its read is answered
	// - a read answers on the edge after its address is taken
	// - a write answers one edge after both halves are held
	// - the answer stands until the master's ready is sampled high
	// One read, and one held write beside one answered write, at most
	// are in flight; a further address waits, which keeps the logic to plain flags and no queue.
	// EEPROM loads are level sensitive and win over software in the
	// same cycle, so a load held high masks every software write except to the lock control register.

	// ****************************************
	// Field storage
	// ****************************************
	logic [3:0]  port_type;
	logic        slot_present;
	logic [2:0]  largest_payload_supported;
	logic [2:0]  indicator_presence;   // {power, attention ind, attention btn}

	// ****************************************
	// Write channel holding
	// ****************************************
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// ****************************************
	// Write decode
	// ****************************************
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire write_go = aw_held & w_held & ~s_axi_bvalid;
	wire [11:0] wr_word = {aw_addr[11:2], 2'b00};
	wire hit_header = (wr_word == capability_header_offset);
	wire hit_devcap = (wr_word == device_capabilities_offset);
	wire hit_lock   = (wr_word == lock_control_offset);
	wire wr_mapped  = hit_header | hit_devcap | hit_lock;
	// Software may touch loadable fields only while the lock is open
	wire sw_header  = write_go & hit_header & lock_open;
	wire sw_devcap  = write_go & hit_devcap & lock_open;
	// Byte enables per field; the lock itself is never locked
	wire wr_port_type_en = sw_header & w_strb[2];
	wire wr_slot_en      = sw_header & w_strb[3];
	wire wr_payload_en   = sw_devcap & w_strb[0];
	wire wr_lock_en      = write_go & hit_lock & w_strb[0];

	// ****************************************
	// Write handshake
	// ****************************************
	// Channel handshakes, either order, one write held at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_awready;
			s_axi_wready  <= ~w_held & ~w_take & ~s_axi_wready;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (write_go) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (write_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response follows both halves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else if (write_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? resp_okay : resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Register updates
	// ****************************************
	// Lock control register, bit 0 opens the lock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_open <= lock_open_reset;
		end else if (wr_lock_en) begin
			lock_open <= w_data[0];
		end
	end

	// Header loadable fields; EEPROM load wins and ignores the lock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_type    <= port_type_reset;
			slot_present <= slot_present_reset;
		end else if (eeprom_load) begin
			port_type    <= eeprom_port_type;
			slot_present <= eeprom_slot_present;
		end else begin
			if (wr_port_type_en) begin
				port_type <= w_data[port_type_lsb +: 4];
			end
			if (wr_slot_en) begin
				slot_present <= w_data[slot_present_bit];
			end
		end
	end

	// Device capability fields; indicator bits have no software path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			largest_payload_supported <= largest_payload_reset;
			indicator_presence        <= indicator_presence_reset;
		end else if (eeprom_load) begin
			largest_payload_supported <= eeprom_largest_payload;
			indicator_presence        <= eeprom_indicator_presence;
		end else if (wr_payload_en) begin
			largest_payload_supported <= w_data[payload_lsb +: 3];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Header fields, one named wire per field so that a field can be
	// probed on its own and the word assembly below stays readable
	wire [7:0]  rd_capability_identifier;
	wire [7:0]  rd_following_link;
	wire [3:0]  rd_structure_version;
	wire [3:0]  rd_port_type;
	wire        rd_slot_present;
	wire [4:0]  rd_message_number;
	wire [1:0]  rd_header_reserved;

	// Fixed fields come straight from the package constants
	assign rd_capability_identifier = capability_identifier;
	assign rd_following_link        = following_capability_link;
	assign rd_structure_version     = structure_version;
	assign rd_message_number        = interrupt_message_number;
	// Reserved bits are tied low; nothing is stored behind them
	assign rd_header_reserved       = 2'b00;

	// Loadable fields read back whatever was last stored
	assign rd_port_type             = port_type;
	assign rd_slot_present          = slot_present;

	// Device capability fields
	wire [2:0]  rd_payload_code;
	wire [1:0]  rd_phantom_bits;
	wire        rd_wide_tag;
	wire [2:0]  rd_l0s_limit;
	wire [2:0]  rd_l1_limit;
	wire        rd_button_present;
	wire        rd_attention_present;
	wire        rd_power_present;
	wire [16:0] rd_devcap_reserved;

	// Constant and stored capability fields
	assign rd_payload_code      = largest_payload_supported;
	assign rd_phantom_bits      = phantom_function_bits;
	assign rd_wide_tag          = wide_tag_supported;
	// Latency limits report the all-ones code, not a measured time
	assign rd_l0s_limit         = l0s_exit_latency_limit;
	assign rd_l1_limit          = l1_exit_latency_limit;
	// Presence bits have no write path; only a load moves them
	assign rd_button_present    = indicator_presence[0];
	assign rd_attention_present = indicator_presence[1];
	assign rd_power_present     = indicator_presence[2];
	assign rd_devcap_reserved   = 17'h00000;

	// ****************************************
	// Word assembly
	// ****************************************
	wire [31:0] header_word;
	wire [31:0] devcap_word;

	// Header word, most significant field first
	assign header_word = {
		rd_header_reserved,
		rd_message_number,
		rd_slot_present,
		rd_port_type,
		rd_structure_version,
		rd_following_link,
		rd_capability_identifier
	};

	// Device capabilities word, most significant field first
	assign devcap_word = {
		rd_devcap_reserved,
		rd_power_present,
		rd_attention_present,
		rd_button_present,
		rd_l1_limit,
		rd_l0s_limit,
		rd_wide_tag,
		rd_phantom_bits,
		rd_payload_code
	};

	// ****************************************
	// Read decode
	// ****************************************
	wire [11:0] rd_word;
	wire        rd_header;
	wire        rd_devcap;
	wire        rd_lock;
	wire        rd_mapped;
	wire [31:0] lock_word;
	wire [31:0] rd_value;

	// Low address bits never select; each register is one word
	assign rd_word   = {s_axi_araddr[11:2], 2'b00};
	assign rd_header = (rd_word == capability_header_offset);
	assign rd_devcap = (rd_word == device_capabilities_offset);
	assign rd_lock   = (rd_word == lock_control_offset);
	assign rd_mapped = rd_header | rd_devcap | rd_lock;
	// Lock state sits alone in bit 0 of its word
	assign lock_word = {31'h00000000, lock_open};
	// Unmapped words read zero and answer with an error
	assign rd_value  = rd_header ? header_word :
		rd_devcap ? devcap_word :
		rd_lock ? lock_word : 32'h0000_0000;

	// ****************************************
	// Read handshake
	// ****************************************
	wire ar_take = s_axi_arvalid & s_axi_arready;

	// One read at a time; address accepted only when no data pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= resp_okay;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_value;
				s_axi_rresp  <= rd_mapped ? resp_okay : resp_slverr;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // pcie_capability_header_regs
`default_nettype wire

// ### testbench/pcie_capability_header_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pcie_capability_header_regs_sva
	import cap_header_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        eeprom_load,
	input wire logic [2:0]  eeprom_largest_payload,
	input wire logic [2:0]  eeprom_indicator_presence
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Read taken per register; data lands a cycle later
	wire        ar = s_axi_arvalid && s_axi_arready;
	wire        hd = ar && s_axi_araddr == capability_header_offset;
	wire        dc = ar && s_axi_araddr == device_capabilities_offset;
	wire [31:0] d  = s_axi_rdata;
	wire [2:0]  ip = eeprom_indicator_presence;
	wire [2:0]  lp = eeprom_largest_payload;
	a_hdr_id: assert property (hd |=> d[15:0] == 16'h6410) else $error("id");
	a_hdr_ver: assert property (hd |=> d[19:16] == 4'h1) else $error("ver");
	a_hdr_msg: assert property (hd |=> d[29:25] == 5'h00) else $error("msg");
	a_hdr_rsvd: assert property (hd |=> d[31:30] == 2'h0) else $error("rsvd");
	a_dcap_fix: assert property (dc |=> d[5:3] == 3'h4) else $error("tag");
	a_dcap_lat: assert property (dc |=> d[11:6] == 6'h3f) else $error("lat");
	a_dcap_rsvd: assert property (dc |=> d[31:15] == 17'h0) else $error("rsvd");
	// Load one cycle before the read is taken, two before it shows; a reset cycle is excluded
	a_dcap_load: assert property (dc && $past(eeprom_load) && $past(aresetn) |=>
		{d[14:12], d[2:0]} == {$past(ip, 2), $past(lp, 2)}) else $error("load");
	// Main traffic
	c_hdr: cover property (hd);
	c_dcap: cover property (dc);
	c_load: cover property (dc && eeprom_load);
endmodule // pcie_capability_header_regs_sva
bind pcie_capability_header_regs
	pcie_capability_header_regs_sva pcie_capability_header_regs_sva_i (.*);
`default_nettype wire

// ### testbench/pcie_capability_header_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pcie_capability_header_regs_tb_top;
	import cap_header_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        eeprom_load = 1'b0, eeprom_slot_present = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lock_open;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0, eeprom_port_type = 4'h0;
	logic [2:0]  eeprom_largest_payload = 3'h0, eeprom_indicator_presence = 3'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          failures = 0, checks_done = 0;
	// 50 MHz clock
	always #10 aclk = ~aclk;
	pcie_capability_header_regs pcie_capability_header_regs_i (.*);
	// Case equality, so an unknown never matches
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g === e) return;
		failures++;
		$display("ERROR %s expected %h seen %h", nm, e, g);
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One transfer; each valid drops once taken, the wait is bounded
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, e,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if ((w ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 64) failures++;
		if (n == 64) give_verdict();
		chk("resp", {30'h0, er}, {30'h0, w ? s_axi_bresp : s_axi_rresp});
		if (!w) chk("rdata", e, s_axi_rdata);
	endtask
	// Reset, then the test sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		xfer(0, 12'h040, 0, 32'h00016410, 0, resp_okay);
		xfer(0, 12'h044, 0, 32'h00000fe4, 0, resp_okay);
		$display("test reset done");
		xfer(1, 12'h040, 32'hffffffff, 0, 4'hf, resp_okay);
		xfer(0, 12'h040, 0, 32'h00016410, 0, resp_okay);
		$display("test locked done");
		xfer(1, lock_control_offset, 32'h1, 0, 4'h1, resp_okay);
		chk("lock_open", 32'h1, {31'h0, lock_open});
		xfer(1, 12'h040, 32'hffffffff, 0, 4'hf, resp_okay);
		xfer(0, 12'h040, 0, 32'h01f16410, 0, resp_okay);
		xfer(1, 12'h044, 32'hffffffff, 0, 4'hf, resp_okay);
		xfer(0, 12'h044, 0, 32'h00000fe7, 0, resp_okay);
		$display("test unlocked done");
		{eeprom_port_type, eeprom_largest_payload, eeprom_indicator_presence} <= 10'h295;
		eeprom_slot_present <= 1'b1;
		eeprom_load <= 1'b1;
		xfer(0, 12'h040, 0, 32'h01a16410, 0, resp_okay);
		xfer(0, 12'h044, 0, 32'h00005fe2, 0, resp_okay);
		eeprom_load <= 1'b0;
		xfer(0, 12'h100, 0, 32'h0, 0, resp_slverr);
		$display("test load done");
		give_verdict();
	end
endmodule // pcie_capability_header_regs_tb_top
`default_nettype wire
